/* logic/ibt_core.sv */
// I2C byte engine with bus timing generation, input sampling and an APB register file.
// Assumes SCL and SDA are open-drain wires resolved outside from the enables.
//
// Function
// - Bus busy may clear before SCL has been driven low.
// - Enabled transmit: data write or FIFO-to-shift move launches the next byte.
// - Enabled receive: data read or shift-to-buffer move launches the next byte.
// - SCL period 28 to 256 cycles, high and low each half.
// - Bus free time after stop is half period minus one cycle.
// - Start hold: SCL high half period minus one after SDA falls.
// - Repeated start: SCL and SDA high one full period first.
// - Stop setup: SCL high half period plus two before SDA rises.
// - Master data setup is SCL low time minus three cycles.
// - Slave data setup is observed SCL low time minus three cycles.
// - SDA keeps its level three cycles after each SCL fall.
// - SCL and SDA inputs are sampled on the core clock.
// - Master follows the real SCL level bit by bit.
// - Slow SCL rise beyond 7.5 or 17.5 cycles extends the high phase.
// - Range bit and clock select field set the period.
`timescale 1ns/1ps

module ibt_fifo import ibt_pkg::*; #(
	parameter int W = DATA_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("FIFO depth must be a power of two");
	end
	logic [W-1:0] mem [DEPTH];
	logic [AW:0] wp_q;
	logic [AW:0] rp_q;
	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;
	assign in_ready = !((wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]));
	assign out_valid = wp_q != rp_q;
	assign out_data = mem[rp_q[AW-1:0]];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			wp_q <= wp_q + (AW+1)'(push);
			rp_q <= rp_q + (AW+1)'(pop);
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_q[AW-1:0]] <= in_data;
		end
	end
endmodule // ibt_fifo

module ibt_core import ibt_pkg::*; (
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SCL_O,
	output logic SCL_OE,
	output logic SDA_O,
	output logic SDA_OE
);
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic [7:0] ctrl_q;
	logic start_req_q;
	logic stop_req_q;
	logic rx_arm_q;
	logic [1:0] s1_q;
	logic [1:0] s2_q;
	logic [1:0] s3_q;
	logic [1:0] line_q;
	logic [1:0] prev_q;
	logic busy_q;
	ibt_state_e state_q;
	logic [8:0] cnt_q;
	logic [3:0] bit_q;
	logic [7:0] shift_q;
	logic scl_oe_q;
	logic sda_oe_q;
	logic own_q;
	logic hi_seen_q;
	logic ackr_q;
	logic [7:0] rxbuf_q;
	logic rxv_q;
	logic pend_q;
	logic drv_lvl_q;
	logic fifo_in_ready;
	logic fifo_valid;
	logic [7:0] fifo_data;

	// Register side decode.
	wire access = PSEL & PENABLE;
	wire done = access & pready_q;
	wire is_ctrl = PADDR == IBT_CTRL_OFS;
	wire is_stat = PADDR == IBT_STAT_OFS;
	wire is_data = PADDR == IBT_DATA_OFS;
	wire mapped = is_ctrl | is_stat | is_data;
	wire ctrl_wr = done & PWRITE & is_ctrl;
	wire data_wr = done & PWRITE & is_data;
	wire data_rd = done & ~PWRITE & is_data;
	// A data write against a full FIFO is held off, not dropped.
	wire wr_stall = PWRITE & is_data & ~fifo_in_ready;
	wire en = ctrl_q[CTRL_EN];
	wire dir = ctrl_q[CTRL_DIR];
	wire mst = ctrl_q[CTRL_MST];
	wire [8:0] period = ibt_period(ctrl_q[CTRL_RR], ctrl_q[CTRL_CKS +: 3]);
	wire [8:0] half = {1'b0, period[8:1]};
	wire [8:0] half_m1 = half - FREE_TRIM_CYC;
	wire [8:0] stoh = half + STOP_EXTRA_CYC;
	wire [8:0] thr = ctrl_q[CTRL_RR] ? THR_HI_CYC : THR_LO_CYC;
	wire [8:0] cnt_inc = cnt_q + 9'h001;
	wire [8:0] hold_m1 = SDA_HOLD_CYC - 9'h001;
	wire [31:0] stat_word = {24'h0, ~fifo_in_ready, ~fifo_valid, ackr_q, own_q,
		rxv_q, line_q[1], line_q[0], busy_q};
	wire [31:0] rdata = is_ctrl ? {24'h0, ctrl_q} : is_stat ? stat_word :
		is_data ? {24'h0, rxbuf_q} : 32'h0;

	// Bus condition detection on the filtered lines.
	wire scl_f = line_q[0];
	wire sda_f = line_q[1];
	wire scl_rise = scl_f & ~prev_q[0];
	wire start_det = scl_f & prev_q[0] & prev_q[1] & ~sda_f;
	wire stop_det = scl_f & prev_q[0] & ~prev_q[1] & sda_f;

	// Engine launch terms.
	wire idle = state_q == IBT_IDLE;
	wire slv_ok = ~mst & busy_q & ~scl_f;
	wire can_go = idle & en & ((mst & own_q & ~start_req_q & ~stop_req_q) | slv_ok);
	wire tx_go = can_go & dir & fifo_valid;
	wire rx_go = can_go & ~dir & rx_arm_q & ~pend_q;
	wire start_take = idle & en & mst & start_req_q & (own_q | ~busy_q);
	wire stop_take = idle & en & mst & own_q & stop_req_q & ~start_req_q;
	wire last = bit_q == 4'h8;
	wire drive_bit = last ? (~dir & ~ctrl_q[CTRL_NACK]) : (dir & ~shift_q[7]);
	wire samp = scl_rise & (state_q == IBT_LOW || state_q == IBT_HIGH);
	wire hi_other = state_q == IBT_HIGH & mst & hi_seen_q & ~scl_f;
	wire hi_end = state_q == IBT_HIGH & (mst ? (hi_other | (scl_f & hi_seen_q &
		cnt_q == half_m1)) : (~scl_f & prev_q[0]));
	wire byte_done = hi_end & last;

	assign PRDATA = prdata_q;
	assign PREADY = pready_q;
	assign PSLVERR = pslverr_q;
	assign SCL_OE = scl_oe_q;
	assign SDA_OE = sda_oe_q;
	assign SCL_O = drv_lvl_q;
	assign SDA_O = drv_lvl_q;

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
			drv_lvl_q <= 1'b0;
		end else begin
			pready_q <= access & ~pready_q & ~wr_stall;
			pslverr_q <= access & ~pready_q & ~wr_stall & ~mapped;
			prdata_q <= (access & ~pready_q) ? rdata : prdata_q;
			drv_lvl_q <= 1'b0;
		end
	end

	// Commands are sticky until the engine takes them; a new write wins over the take.
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			ctrl_q <= CTRL_RST;
			start_req_q <= 1'b0;
			stop_req_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_wr ? PWDATA[7:0] : ctrl_q;
			start_req_q <= (ctrl_wr & PWDATA[CTRL_START]) |
				(start_req_q & (state_q != IBT_SHOLD));
			stop_req_q <= (ctrl_wr & PWDATA[CTRL_STOP]) | (stop_req_q & ~stop_take);
		end
	end

	// Two-stage synchroniser, then a match filter on stages two and three.
	for (genvar i = 0; i < 2; i++) begin : g_sync
		always_ff @(posedge CORE_CLK or negedge NRST) begin
			if (!NRST) begin
				s1_q[i] <= 1'b1;
				s2_q[i] <= 1'b1;
				s3_q[i] <= 1'b1;
				line_q[i] <= 1'b1;
				prev_q[i] <= 1'b1;
			end else begin
				s1_q[i] <= i == 0 ? SCL_I : SDA_I;
				s2_q[i] <= s1_q[i];
				s3_q[i] <= s2_q[i];
				line_q[i] <= (s2_q[i] == s3_q[i]) ? s2_q[i] : line_q[i];
				prev_q[i] <= line_q[i];
			end
		end
	end

	// Busy follows bus conditions only, so it can clear ahead of our own SCL.
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= start_det | (busy_q & ~stop_det);
		end
	end

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			shift_q <= 8'h0;
			ackr_q <= 1'b1;
		end else begin
			if (tx_go) begin
				shift_q <= fifo_data;
			end else if (samp & ~last) begin
				shift_q <= {shift_q[6:0], sda_f};
			end
			ackr_q <= (samp & last) ? sda_f : ackr_q;
		end
	end

	// Receive buffer: a full buffer parks the byte in the shift register.
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			rxbuf_q <= 8'h0;
			rxv_q <= 1'b0;
			pend_q <= 1'b0;
			rx_arm_q <= 1'b0;
		end else begin
			if (byte_done & ~dir) begin
				if (rxv_q & ~data_rd) begin
					pend_q <= 1'b1;
				end else begin
					rxbuf_q <= shift_q;
					rxv_q <= 1'b1;
				end
			end else if (data_rd) begin
				if (pend_q) begin
					rxbuf_q <= shift_q;
					pend_q <= 1'b0;
				end else begin
					rxv_q <= 1'b0;
				end
			end
			rx_arm_q <= data_rd | (byte_done & ~dir & (~rxv_q | data_rd)) |
				(rx_arm_q & ~rx_go);
		end
	end

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			state_q <= IBT_IDLE;
			cnt_q <= 9'h0;
			bit_q <= 4'h0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			own_q <= 1'b0;
			hi_seen_q <= 1'b0;
		end else begin
			cnt_q <= cnt_inc;
			unique case (state_q)
				IBT_IDLE: begin
					if (tx_go | rx_go) begin
						state_q <= IBT_LOW;
						// A master launch counts its idle cycle, so the data hold stays three cycles.
						cnt_q <= {8'h00, mst};
						bit_q <= 4'h0;
					end else if (start_take) begin
						state_q <= own_q ? IBT_RSU : IBT_FREE;
						cnt_q <= 9'h0;
					end else if (stop_take) begin
						state_q <= IBT_PSTOP;
						cnt_q <= 9'h0;
					end else if (~mst & cnt_q == hold_m1) begin
						sda_oe_q <= 1'b0;
					end
				end
				IBT_LOW: begin
					if (cnt_q == hold_m1) begin
						sda_oe_q <= drive_bit;
					end
					if (mst & cnt_q == half_m1) begin
						scl_oe_q <= 1'b0;
						state_q <= IBT_HIGH;
						cnt_q <= 9'h0;
						hi_seen_q <= 1'b0;
					end else if (~mst & scl_rise) begin
						state_q <= IBT_HIGH;
					end
				end
				IBT_HIGH: begin
					if (hi_end) begin
						scl_oe_q <= mst;
						state_q <= last ? IBT_IDLE : IBT_LOW;
						bit_q <= bit_q + 4'h1;
						cnt_q <= 9'h0;
					end else if (mst & scl_f & ~hi_seen_q) begin
						hi_seen_q <= 1'b1;
						cnt_q <= (cnt_q >= thr) ? 9'h0 : cnt_inc;
					end
				end
				IBT_SHOLD: begin
					if (cnt_q == half_m1 - 9'h001) begin
						scl_oe_q <= 1'b1;
						own_q <= 1'b1;
						state_q <= IBT_IDLE;
						cnt_q <= 9'h0;
					end
				end
				IBT_RSU: begin
					if (scl_oe_q) begin
						sda_oe_q <= (cnt_q == hold_m1) ? 1'b0 : sda_oe_q;
						if (cnt_q == half_m1) begin
							scl_oe_q <= 1'b0;
							cnt_q <= 9'h0;
						end
					end else if (~scl_f) begin
						cnt_q <= 9'h0;
					end else if (cnt_q == period - 9'h001) begin
						sda_oe_q <= 1'b1;
						state_q <= IBT_SHOLD;
						cnt_q <= 9'h0;
					end
				end
				IBT_PSTOP: begin
					sda_oe_q <= (cnt_q == hold_m1) ? 1'b1 : sda_oe_q;
					if (cnt_q == half_m1) begin
						scl_oe_q <= 1'b0;
						state_q <= IBT_STOPH;
						cnt_q <= 9'h0;
					end
				end
				IBT_STOPH: begin
					if (~scl_f) begin
						cnt_q <= 9'h0;
					end else if (cnt_q == stoh - 9'h001) begin
						sda_oe_q <= 1'b0;
						own_q <= 1'b0;
						state_q <= IBT_FREE;
						cnt_q <= 9'h0;
					end
				end
				IBT_FREE: begin
					// Too short for some slaves; software adds its own gap.
					if (cnt_q >= half_m1 - 9'h001) begin
						cnt_q <= 9'h0;
						if (start_req_q & ~busy_q & en & mst) begin
							sda_oe_q <= 1'b1;
							state_q <= IBT_SHOLD;
						end else begin
							state_q <= IBT_IDLE;
						end
					end
				end
			endcase
		end
	end

	ibt_fifo #(
		.W(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_txq (
		.clk(CORE_CLK),
		.rst_n(NRST),
		.in_valid(data_wr),
		.in_data(PWDATA[7:0]),
		.in_ready(fifo_in_ready),
		.out_valid(fifo_valid),
		.out_data(fifo_data),
		.out_ready(tx_go)
	);

	logic [8:0] lowc_q;
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			lowc_q <= 9'h0;
		end else begin
			lowc_q <= scl_oe_q ? lowc_q + 9'h001 : 9'h0;
		end
	end

	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);

	sequence s_sda_held;
		$stable(sda_oe_q) [*3];
	endsequence

	scl_fall_hold_a: assert property ($rose(scl_oe_q) |-> s_sda_held)
		else $error("SDA changed within three cycles of SCL fall");
	tx_launch_a: assert property (tx_go |=> state_q == IBT_LOW && bit_q == 4'h0)
		else $error("Transmit launch did not start a byte");
	rx_launch_a: assert property (rx_go |=> state_q == IBT_LOW && !rx_arm_q)
		else $error("Receive launch did not start a byte");
	low_len_a: assert property ($fell(scl_oe_q) && $past(state_q) == IBT_LOW
		&& $past(bit_q) != 4'h0 |-> lowc_q == $past(half))
		else $error("SCL low phase not half the period");
	data_setup_a: assert property (state_q == IBT_LOW && $changed(sda_oe_q)
		|-> cnt_q == SDA_HOLD_CYC)
		else $error("Data bit placed at wrong cycle");
	start_hold_a: assert property ($rose(scl_oe_q) && $past(state_q) == IBT_SHOLD
		|-> $past(cnt_q) == $past(half_m1) - 9'h001 && sda_oe_q)
		else $error("Start hold time wrong");
	stop_setup_a: assert property ($fell(sda_oe_q) && $past(state_q) == IBT_STOPH
		|-> $past(cnt_q) == $past(stoh) - 9'h001 && !scl_oe_q)
		else $error("Stop setup time wrong");
	open_drain_a: assert property (!SCL_O && !SDA_O)
		else $error("Line driven high");
endmodule // ibt_core

/* common/ibt_pkg.sv */
// Shared constants, register layout and state type of the I2C timing block.
// Assumes a single 100 MHz core clock and an APB master on the register side.
package ibt_pkg;
	localparam int CLK_MHZ = 100;
	localparam logic [7:0] IBT_CTRL_OFS = 8'h00;
	localparam logic [7:0] IBT_STAT_OFS = 8'h04;
	localparam logic [7:0] IBT_DATA_OFS = 8'h08;
	localparam int CTRL_EN = 0;
	localparam int CTRL_DIR = 1;
	localparam int CTRL_MST = 2;
	localparam int CTRL_RR = 3;
	localparam int CTRL_CKS = 4;
	localparam int CTRL_NACK = 7;
	localparam int CTRL_START = 8;
	localparam int CTRL_STOP = 9;
	localparam int STAT_BUSY = 0;
	localparam int STAT_SCL = 1;
	localparam int STAT_SDA = 2;
	localparam int STAT_RXV = 3;
	localparam int STAT_OWN = 4;
	localparam int STAT_ACK = 5;
	localparam int STAT_TXE = 6;
	localparam int STAT_FULL = 7;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [8:0] SDA_HOLD_CYC = 9'h003;
	localparam logic [8:0] STOP_EXTRA_CYC = 9'h002;
	localparam logic [8:0] FREE_TRIM_CYC = 9'h001;
	localparam int THR_LO_TENTHS = 75;
	localparam int THR_HI_TENTHS = 175;
	localparam logic [8:0] THR_LO_CYC = 9'((THR_LO_TENTHS + 9) / 10);
	localparam logic [8:0] THR_HI_CYC = 9'((THR_HI_TENTHS + 9) / 10);
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 32;
	localparam logic [8:0] PER_MIN = 9'h01c;

	typedef enum logic [2:0] {
		IBT_IDLE = 3'b000,
		IBT_LOW = 3'b001,
		IBT_HIGH = 3'b011,
		IBT_SHOLD = 3'b010,
		IBT_PSTOP = 3'b110,
		IBT_STOPH = 3'b111,
		IBT_FREE = 3'b101,
		IBT_RSU = 3'b100
	} ibt_state_e;

	// SCL period in core cycles; the range bit doubles the base period.
	function automatic logic [8:0] ibt_period(input logic rr, input logic [2:0] cks);
		logic [8:0] base;
		base = 9'h01c;
		unique case (cks)
			3'h0: base = 9'h01c;
			3'h1: base = 9'h028;
			3'h2: base = 9'h030;
			3'h3: base = 9'h040;
			3'h4: base = 9'h050;
			3'h5: base = 9'h064;
			3'h6: base = 9'h070;
			3'h7: base = 9'h080;
		endcase
		return rr ? {base[7:0], 1'b0} : base;
	endfunction
endpackage

/* bench/ibt_peer.sv */
// Behavioural I2C slave that sits on the far side of the timing block.
// Assumes wired-AND lines that the bench resolves, with pull-ups to high.
`timescale 1ns/1ps

module ibt_peer (
	input wire logic clk,
	input wire logic scl,
	input wire logic sda,
	input wire logic rd_mode,
	input wire logic [7:0] tx_byte,
	input wire logic [7:0] stretch,
	output logic scl_oe,
	output logic sda_oe,
	output logic [7:0] got,
	output logic ack,
	output int nb
);
	logic scl_p = 1'b1;
	logic sda_p = 1'b1;
	logic act = 1'b0;
	logic [7:0] sh = 8'h00;
	int idx = 0;
	int hold = 0;

	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
		got = 8'h00;
		ack = 1'b1;
		nb = 0;
	end

	// The slave reacts to the raw lines, so it changes data right at the fall it sees.
	always @(posedge clk) begin
		if (scl && sda_p && !sda) begin
			act = 1'b1;
			idx = 8;
		end else if (scl && !sda_p && sda) begin
			act = 1'b0;
		end
		if (act && scl_p && !scl) begin
			idx = (idx == 8) ? 0 : idx + 1;
			hold = stretch;
			sda_oe <= rd_mode ? (idx < 8 && !tx_byte[7 - idx]) : (idx == 8);
		end
		if (act && !scl_p && scl) begin
			if (idx < 8) sh = {sh[6:0], sda};
			if (idx == 7 && !rd_mode) begin
				got <= sh;
				nb <= nb + 1;
			end
			if (idx == 8) ack <= sda;
		end
		if (!act) sda_oe <= 1'b0;
		scl_oe <= (hold > 0);
		if (hold > 0) hold = hold - 1;
		scl_p = scl;
		sda_p = sda;
	end
endmodule // ibt_peer

/* bench/tb.sv */
// Self-checking bench for the I2C timing block with an APB master.
// Assumes the slave model in ibt_peer and open-drain lines with pull-ups.
`timescale 1ns/1ps

`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

module tb import ibt_pkg::*; ;
	logic CORE_CLK = 1'b0;
	logic NRST = 1'b0;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0;
	logic [31:0] PRDATA;
	logic PREADY, PSLVERR, SCL_O, SCL_OE, SDA_O, SDA_OE, p_scl, p_sda, p_ack, err;
	logic rd_mode = 1'b0;
	logic [7:0] tx_byte = 8'h00;
	logic [7:0] stretch = 8'h00;
	logic [7:0] p_got;
	logic [31:0] rd;
	int p_nb, mismatches = 0, checks_done = 0, cyc = 0;
	int lc = 0, fc = 0, sd = 0, lh = 0, hmin, hmax, lomin, shold, lhmin, stop_t, rs_t = 0;
	logic scl_q = 1'b0, sda_q = 1'b0, lq = 1'b1;
	wire scl = ~(SCL_OE | p_scl);
	wire sda = ~(SDA_OE | p_sda);

	ibt_core i_ibt_core (.CORE_CLK(CORE_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .SCL_I(scl), .SDA_I(sda), .SCL_O(SCL_O), .SCL_OE(SCL_OE),
		.SDA_O(SDA_O), .SDA_OE(SDA_OE));
	ibt_peer i_ibt_peer (.clk(CORE_CLK), .scl(scl), .sda(sda), .rd_mode(rd_mode),
		.tx_byte(tx_byte), .stretch(stretch), .scl_oe(p_scl), .sda_oe(p_sda), .got(p_got),
		.ack(p_ack), .nb(p_nb));

	always #5 CORE_CLK = ~CORE_CLK;

	// Edge timing of the drives, counted in core cycles; the bench keeps the extremes.
	always @(posedge CORE_CLK) begin
		lc = (SCL_OE && !scl_q) ? 0 : lc + 1;
		fc = (!SCL_OE && scl_q) ? 0 : fc + 1;
		sd = (SDA_OE && !sda_q) ? 0 : sd + 1;
		lh = (scl && !lq) ? 0 : lh + 1;
		if (SDA_OE !== sda_q && scl_q && SCL_OE) begin
			hmin = (lc < hmin) ? lc : hmin;
			hmax = (lc > hmax) ? lc : hmax;
		end
		if (!SCL_OE && scl_q && lc < lomin) lomin = lc;
		if (SCL_OE && !scl_q && sd < shold) shold = sd;
		if (!scl && lq && lh < lhmin) lhmin = lh;
		if (!SDA_OE && sda_q && !SCL_OE) stop_t = fc;
		if (SDA_OE && !sda_q && !SCL_OE) rs_t = fc;
		scl_q = SCL_OE;
		sda_q = SDA_OE;
		lq = scl;
		cyc++;
		if (cyc == 60000) begin
			mismatches++;
			results();
		end
	end

	task automatic results;
		$display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CORE_CLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CORE_CLK);
		PENABLE <= 1'b1;
		@(posedge CORE_CLK);
		while (PREADY !== 1'b1) @(posedge CORE_CLK);
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask

	task automatic wait_stat(input int b, input logic v);
		do apb(1'b0, IBT_STAT_OFS, 32'h0); while (rd[b] !== v);
	endtask

	task automatic clear_mon;
		hmin = 99;
		hmax = 0;
		lomin = 999;
		shold = 999;
		lhmin = 999;
	endtask

	task automatic t_regs;
		apb(1'b0, IBT_CTRL_OFS, 32'h0);
		`CHK(rd, 32'h0)
		apb(1'b1, IBT_STAT_OFS, 32'hff);
		apb(1'b0, IBT_STAT_OFS, 32'h0);
		`CHK(rd, 32'h66)
		apb(1'b1, IBT_CTRL_OFS, 32'h7a);
		apb(1'b0, IBT_CTRL_OFS, 32'h0);
		`CHK(rd, 32'h7a)
		apb(1'b0, 8'h0c, 32'h0);
		`CHK({err, rd}, {1'b1, 32'h0})
		apb(1'b1, IBT_CTRL_OFS, 32'h0);
	endtask

	// Disabled interface: pushed bytes must wait, so the buffer fills to its limit.
	task automatic t_fifo;
		for (int i = 0; i < 32; i++) begin
			apb(1'b1, IBT_DATA_OFS, 32'(i * 7 + 1));
			apb(1'b0, IBT_STAT_OFS, 32'h0);
			`CHK(rd[7:6], (i == 31) ? 2'b10 : 2'b00)
		end
	endtask

	task automatic t_tx;
		stretch <= 8'd60;
		clear_mon();
		apb(1'b1, IBT_CTRL_OFS, 32'h117);
		while (!(SCL_OE === 1'b1 && lc > 40 && p_nb == 32)) @(posedge CORE_CLK);
		`CHK(p_got, 8'hda)
		`CHK({hmin, hmax}, {32'd3, 32'd3})
		`CHK(lomin, 20)
		`CHK(shold, 19)
		`CHK(lhmin >= 20, 1'b1)
		apb(1'b0, IBT_STAT_OFS, 32'h0);
		`CHK({rd[STAT_ACK], rd[STAT_TXE]}, 2'b01)
		stretch <= 8'd0;
	endtask

	task automatic t_stop(input logic [31:0] c, input int h);
		apb(1'b1, IBT_CTRL_OFS, c | 32'h200);
		wait_stat(STAT_BUSY, 1'b0);
		`CHK(stop_t >= h + 2 && stop_t <= h + 8, 1'b1)
		`CHK({scl, sda, SCL_O, SDA_O}, 4'b1100)
		// A microsecond of idle bus before anyone starts again.
		repeat (100) @(posedge CORE_CLK);
	endtask

	task automatic t_rx;
		rd_mode <= 1'b1;
		tx_byte <= 8'ha5;
		clear_mon();
		apb(1'b1, IBT_CTRL_OFS, 32'h10d);
		apb(1'b0, IBT_DATA_OFS, 32'h0);
		wait_stat(STAT_RXV, 1'b1);
		apb(1'b0, IBT_DATA_OFS, 32'h0);
		`CHK(rd, 32'ha5)
		wait_stat(STAT_RXV, 1'b1);
		`CHK(p_ack, 1'b0)
		`CHK({lomin, shold}, {32'd28, 32'd27})
	endtask

	// Software reads both lines low before it commands the next condition.
	task automatic wait_low;
		do apb(1'b0, IBT_STAT_OFS, 32'h0);
		while ({rd[STAT_SDA], rd[STAT_SCL]} !== 2'b00);
	endtask

	// Start, repeated start and stop back to back; the repeated start and the stop each follow both lines reading low.
	task automatic t_ss;
		clear_mon();
		apb(1'b1, IBT_CTRL_OFS, 32'h105);
		wait_low();
		apb(1'b1, IBT_CTRL_OFS, 32'h105);
		wait_stat(STAT_SDA, 1'b1);
		wait_low();
		`CHK(rs_t >= 28 && rs_t <= 36, 1'b1)
		`CHK(shold, 13)
		t_stop(32'h05, 14);
	endtask

	initial begin
		repeat (16) @(posedge CORE_CLK);
		NRST <= 1'b1;
		repeat (8) @(posedge CORE_CLK);
		t_regs();
		t_fifo();
		t_tx();
		t_stop(32'h17, 20);
		t_rx();
		t_stop(32'h0d, 28);
		t_ss();
		results();
	end
endmodule // tb
